/* File: hdl/raw_regs.sv */
/*
 * raw_regs: APB register bank of the radio link-layer core: radio control,
 * power timing, advertising channel map and interval, active-scan counters,
 * filter list pointers and counts, cipher control, key and block pointer.
 * Assumes an APB master on pclk, a cipher engine that pulses cipher_done,
 * and scan counter values offered with a one-cycle load strobe.
 */
// Our own choice: register access over APB.
// What this block does
// - seven-bit round trip latency in microseconds, read and write
// - eight-bit receiver power-up time, resets to 210 microseconds
// - four-bit transmitter power-down extension, resets to 3 microseconds
// - eight-bit transmitter power-up time, resets to 210 microseconds
// - three-bit channel map, bit i enables channel 37+i, all on at reset
// - fourteen-bit spacing in microseconds between advertising packets
// - nine-bit read-only scan retreat initial value, one after reset
// - nine-bit read-only scan ceiling count, one after reset
// - sixteen-bit start address of the public filter list
// - sixteen-bit start address of the private filter list
// - private count in bits 15 to 8, public count in bits 7 to 0
// - writing start launches cipher; mode zero enciphers, one deciphers
// - start bit clears itself when the cipher operation completes
// - key bits 63 to 0 in two read/write words, reset zero
// - key bits 127 to 64 in the next two words
// - sixteen-bit pointer to the data block to cipher
`timescale 1ns/1ns
`default_nettype none
module raw_regs #(
    parameter int KEY_DEPTH = raw_pkg::KEY_WORDS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [raw_pkg::ADDR_W-1:0] paddr,
    input wire logic [raw_pkg::DATA_W-1:0] pwdata,
    input wire logic [raw_pkg::STRB_W-1:0] pstrb,
    output logic [raw_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [raw_pkg::XRS_W-1:0] extended_radio_select,
    output logic [raw_pkg::DATA_W-1:0] radio_ctl_two,
    output logic [raw_pkg::DATA_W-1:0] radio_ctl_three,
    output logic [raw_pkg::RTL_W-1:0] round_trip_latency,
    output logic [raw_pkg::RXPU_W-1:0] receiver_powerup_time,
    output logic [raw_pkg::TXPD_W-1:0] transmitter_powerdown_ext,
    output logic [raw_pkg::TXPU_W-1:0] transmitter_powerup_time,
    output logic [raw_pkg::CHMAP_W-1:0] beacon_channel_map,
    output logic [raw_pkg::SPACING_W-1:0] beacon_packet_spacing,
    input wire logic scan_values_load,
    input wire logic [raw_pkg::SCAN_W-1:0] scan_retreat_value,
    input wire logic [raw_pkg::SCAN_W-1:0] scan_ceiling_value,
    output logic [raw_pkg::PTR_W-1:0] public_list_start,
    output logic [raw_pkg::PTR_W-1:0] private_list_start,
    output logic [raw_pkg::CNT_W-1:0] private_entry_count,
    output logic [raw_pkg::CNT_W-1:0] public_entry_count,
    output logic cipher_start,
    output logic cipher_decipher,
    output logic cipher_busy,
    input wire logic cipher_done,
    output logic [raw_pkg::PTR_W-1:0] cipher_block_pointer,
    input wire logic [raw_pkg::KEY_IDX_W-1:0] key_rd_idx,
    output logic [raw_pkg::DATA_W-1:0] key_rd_data
);
    raw_pkg::raw_apb_state_t state_q;
    raw_pkg::raw_apb_state_t state_d;
    logic [raw_pkg::DATA_W-1:0] img;
    logic [raw_pkg::DATA_W-1:0] wmerged;
    logic [raw_pkg::DATA_W-1:0] key_rdata;
    logic hit;
    logic key_hit;
    logic setup;
    logic commit;
    logic [raw_pkg::SCAN_W-1:0] retreat_q;
    logic [raw_pkg::SCAN_W-1:0] ceiling_q;

    // byte-lane merge of write data over the register's current image
    function automatic logic [raw_pkg::DATA_W-1:0] merge_strb(
        input logic [raw_pkg::DATA_W-1:0] old,
        input logic [raw_pkg::DATA_W-1:0] wdat,
        input logic [raw_pkg::STRB_W-1:0] strb
    );
        logic [raw_pkg::DATA_W-1:0] res;
        res = old;
        for (int b = 0; b < raw_pkg::STRB_W; b++) begin
            if (strb[b]) begin
                res[b*raw_pkg::BYTE_W +: raw_pkg::BYTE_W] = wdat[b*raw_pkg::BYTE_W +: raw_pkg::BYTE_W];
            end
        end
        return res;
    endfunction : merge_strb

    // key words form a contiguous aligned window
    function automatic logic is_key(input logic [raw_pkg::ADDR_W-1:0] a);
        return a >= raw_pkg::A_KEY_WORD0 && a <= raw_pkg::A_KEY_WORD3
            && a[raw_pkg::WORD_LSB-1:0] == '0;
    endfunction : is_key

    function automatic logic [raw_pkg::KEY_IDX_W-1:0] key_index(
        input logic [raw_pkg::ADDR_W-1:0] a
    );
        logic [raw_pkg::ADDR_W-1:0] d;
        d = a - raw_pkg::A_KEY_WORD0;
        return d[raw_pkg::WORD_LSB +: raw_pkg::KEY_IDX_W];
    endfunction : key_index

    assign setup = psel && !penable;
    // a write takes effect only at the edge that completes the transfer
    assign commit = psel && penable && pwrite && state_q == raw_pkg::RAW_ANSWER;
    assign key_hit = is_key(paddr);

    // read image of the addressed register, reserved bits read as zero
    always_comb begin
        img = '0;
        hit = 1'b1;
        case (paddr)
            raw_pkg::A_RADIO_CTL1: begin
                img[raw_pkg::XRS_LSB +: raw_pkg::XRS_W] = extended_radio_select;
            end
            raw_pkg::A_RADIO_CTL2: begin
                img = radio_ctl_two;
            end
            raw_pkg::A_RADIO_CTL3: begin
                img = radio_ctl_three;
            end
            raw_pkg::A_PWR_TIMING: begin
                img[raw_pkg::RTL_LSB +: raw_pkg::RTL_W] = round_trip_latency;
                img[raw_pkg::RXPU_LSB +: raw_pkg::RXPU_W] = receiver_powerup_time;
                img[raw_pkg::TXPD_LSB +: raw_pkg::TXPD_W] = transmitter_powerdown_ext;
                img[raw_pkg::TXPU_LSB +: raw_pkg::TXPU_W] = transmitter_powerup_time;
            end
            raw_pkg::A_CHAN_MAP: begin
                img[raw_pkg::CHMAP_W-1:0] = beacon_channel_map;
            end
            raw_pkg::A_ADV_INTERVAL: begin
                img[raw_pkg::SPACING_W-1:0] = beacon_packet_spacing;
            end
            raw_pkg::A_SCAN_COUNTERS: begin
                img[raw_pkg::RETREAT_LSB +: raw_pkg::SCAN_W] = retreat_q;
                img[raw_pkg::CEIL_LSB +: raw_pkg::SCAN_W] = ceiling_q;
            end
            raw_pkg::A_PUB_LIST_PTR: begin
                img[raw_pkg::PTR_W-1:0] = public_list_start;
            end
            raw_pkg::A_PRIV_LIST_PTR: begin
                img[raw_pkg::PTR_W-1:0] = private_list_start;
            end
            raw_pkg::A_LIST_COUNTS: begin
                img[raw_pkg::PRIVCNT_LSB +: raw_pkg::CNT_W] = private_entry_count;
                img[raw_pkg::PUBCNT_LSB +: raw_pkg::CNT_W] = public_entry_count;
            end
            raw_pkg::A_CIPHER_CTL: begin
                img[raw_pkg::START_BIT] = cipher_busy;
                img[raw_pkg::MODE_BIT] = cipher_decipher;
            end
            raw_pkg::A_BLOCK_PTR: begin
                img[raw_pkg::PTR_W-1:0] = cipher_block_pointer;
            end
            default: begin
                img = key_rdata;
                hit = key_hit;
            end
        endcase
    end

    assign wmerged = merge_strb(img, pwdata, pstrb);

    // apb answer sequencer: setup, fetch cycle, answer cycle with pready
    always_comb begin
        case (state_q)
            raw_pkg::RAW_IDLE: state_d = setup ? raw_pkg::RAW_FETCH : raw_pkg::RAW_IDLE;
            raw_pkg::RAW_FETCH: state_d = raw_pkg::RAW_ANSWER;
            raw_pkg::RAW_ANSWER: state_d = raw_pkg::RAW_IDLE;
            default: state_d = raw_pkg::RAW_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= raw_pkg::RAW_IDLE;
        end else if (pce) begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (pce) begin
            pready <= state_q == raw_pkg::RAW_FETCH;
            pslverr <= state_q == raw_pkg::RAW_FETCH && !hit;
            if (state_q == raw_pkg::RAW_FETCH) begin
                prdata <= (hit && !pwrite) ? img : '0;
            end
        end
    end

    // radio control words, the first holds only the extended select field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            extended_radio_select <= '0;
            radio_ctl_two <= '0;
            radio_ctl_three <= raw_pkg::RADIO_CTL3_RST;
        end else if (pce && commit) begin
            if (paddr == raw_pkg::A_RADIO_CTL1) begin
                extended_radio_select <= wmerged[raw_pkg::XRS_LSB +: raw_pkg::XRS_W];
            end
            if (paddr == raw_pkg::A_RADIO_CTL2) begin
                radio_ctl_two <= wmerged;
            end
            if (paddr == raw_pkg::A_RADIO_CTL3) begin
                radio_ctl_three <= wmerged;
            end
        end
    end

    // radio power-up, power-down and round-trip timing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            round_trip_latency <= '0;
            receiver_powerup_time <= raw_pkg::RXPU_RST;
            transmitter_powerdown_ext <= raw_pkg::TXPD_RST;
            transmitter_powerup_time <= raw_pkg::TXPU_RST;
        end else if (pce && commit && paddr == raw_pkg::A_PWR_TIMING) begin
            round_trip_latency <= wmerged[raw_pkg::RTL_LSB +: raw_pkg::RTL_W];
            receiver_powerup_time <= wmerged[raw_pkg::RXPU_LSB +: raw_pkg::RXPU_W];
            transmitter_powerdown_ext <= wmerged[raw_pkg::TXPD_LSB +: raw_pkg::TXPD_W];
            transmitter_powerup_time <= wmerged[raw_pkg::TXPU_LSB +: raw_pkg::TXPU_W];
        end
    end

    // advertising channel map and packet spacing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            beacon_channel_map <= raw_pkg::CHMAP_RST;
            beacon_packet_spacing <= '0;
        end else if (pce && commit) begin
            if (paddr == raw_pkg::A_CHAN_MAP) begin
                beacon_channel_map <= wmerged[raw_pkg::CHMAP_W-1:0];
            end
            if (paddr == raw_pkg::A_ADV_INTERVAL) begin
                beacon_packet_spacing <= wmerged[raw_pkg::SPACING_W-1:0];
            end
        end
    end

    // scan counter values come from the link layer, software only reads them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            retreat_q <= raw_pkg::SCAN_RST;
            ceiling_q <= raw_pkg::SCAN_RST;
        end else if (pce && scan_values_load) begin
            retreat_q <= scan_retreat_value;
            ceiling_q <= scan_ceiling_value;
        end
    end

    // filter list start pointers and entry counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            public_list_start <= '0;
            private_list_start <= '0;
            private_entry_count <= '0;
            public_entry_count <= '0;
        end else if (pce && commit) begin
            if (paddr == raw_pkg::A_PUB_LIST_PTR) begin
                public_list_start <= wmerged[raw_pkg::PTR_W-1:0];
            end
            if (paddr == raw_pkg::A_PRIV_LIST_PTR) begin
                private_list_start <= wmerged[raw_pkg::PTR_W-1:0];
            end
            if (paddr == raw_pkg::A_LIST_COUNTS) begin
                private_entry_count <= wmerged[raw_pkg::PRIVCNT_LSB +: raw_pkg::CNT_W];
                public_entry_count <= wmerged[raw_pkg::PUBCNT_LSB +: raw_pkg::CNT_W];
            end
        end
    end

    // block pointer is not locked while busy; software keeps it still
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cipher_block_pointer <= '0;
        end else if (pce && commit && paddr == raw_pkg::A_BLOCK_PTR) begin
            cipher_block_pointer <= wmerged[raw_pkg::PTR_W-1:0];
        end
    end

    raw_cipher_ctl u_cipher_ctl (
        .clk(pclk),
        .rst_n(presetn),
        .ce(pce),
        // a write that leaves the start byte lane off must not relaunch from the busy image
        .ctl_wr(commit && paddr == raw_pkg::A_CIPHER_CTL
            && pstrb[raw_pkg::START_BIT / raw_pkg::BYTE_W]),
        .start_val(wmerged[raw_pkg::START_BIT]),
        .mode_val(wmerged[raw_pkg::MODE_BIT]),
        .done(cipher_done),
        .busy_q(cipher_busy),
        .mode_q(cipher_decipher),
        .start_pulse_q(cipher_start)
    );

    // key words: port a serves the bus, port b serves the cipher engine
    raw_key_mem #(
        .WIDTH(raw_pkg::DATA_W),
        .DEPTH(KEY_DEPTH),
        .IDX_W(raw_pkg::KEY_IDX_W)
    ) u_key_mem (
        .clk(pclk),
        .rst_n(presetn),
        .ce(pce),
        .wr_en(commit && key_hit),
        .wr_idx(key_index(paddr)),
        .wr_strb(pstrb),
        .wr_data(pwdata),
        .rda_idx(key_index(paddr)),
        .rda_data_q(key_rdata),
        .rdb_idx(key_rd_idx),
        .rdb_data_q(key_rd_data)
    );
endmodule : raw_regs
`default_nettype wire

/* File: shared/raw_pkg.sv */
/*
 * raw_pkg: register map, field layout, reset values and state codes of the
 * radio link-layer control register bank.
 * Assumes a 32-bit APB slave; every register takes one aligned word.
 */
`default_nettype none
package raw_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam int STRB_W = 4;
    localparam int BYTE_W = 8;

    // register byte addresses
    localparam logic [31:0] A_RADIO_CTL1 = 32'h4000_0074;
    localparam logic [31:0] A_RADIO_CTL2 = 32'h4000_0078;
    localparam logic [31:0] A_RADIO_CTL3 = 32'h4000_007c;
    localparam logic [31:0] A_PWR_TIMING = 32'h4000_0080;
    localparam logic [31:0] A_CHAN_MAP = 32'h4000_0090;
    localparam logic [31:0] A_ADV_INTERVAL = 32'h4000_00a0;
    localparam logic [31:0] A_SCAN_COUNTERS = 32'h4000_00a4;
    localparam logic [31:0] A_PUB_LIST_PTR = 32'h4000_00b0;
    localparam logic [31:0] A_PRIV_LIST_PTR = 32'h4000_00b4;
    localparam logic [31:0] A_LIST_COUNTS = 32'h4000_00b8;
    localparam logic [31:0] A_CIPHER_CTL = 32'h4000_00c0;
    localparam logic [31:0] A_KEY_WORD0 = 32'h4000_00c4;
    localparam logic [31:0] A_KEY_WORD3 = 32'h4000_00d0;
    localparam logic [31:0] A_BLOCK_PTR = 32'h4000_00d4;

    // key words occupy consecutive words starting at key word 0
    localparam int KEY_WORDS = 4;
    localparam int KEY_IDX_W = 2;
    localparam int WORD_LSB = 2;

    // field positions and widths
    localparam int XRS_LSB = 16;
    localparam int XRS_W = 5;
    localparam int RTL_LSB = 24;
    localparam int RTL_W = 7;
    localparam int RXPU_LSB = 16;
    localparam int RXPU_W = 8;
    localparam int TXPD_LSB = 8;
    localparam int TXPD_W = 4;
    localparam int TXPU_LSB = 0;
    localparam int TXPU_W = 8;
    localparam int CHMAP_W = 3;
    localparam int SPACING_W = 14;
    localparam int RETREAT_LSB = 16;
    localparam int SCAN_W = 9;
    localparam int CEIL_LSB = 0;
    localparam int PTR_W = 16;
    localparam int PRIVCNT_LSB = 8;
    localparam int PUBCNT_LSB = 0;
    localparam int CNT_W = 8;
    localparam int START_BIT = 0;
    localparam int MODE_BIT = 1;

    // reset values
    localparam logic [31:0] RADIO_CTL3_RST = 32'h0000_0040;
    localparam logic [7:0] RXPU_RST = 8'hd2;
    localparam logic [3:0] TXPD_RST = 4'h3;
    localparam logic [7:0] TXPU_RST = 8'hd2;
    localparam logic [2:0] CHMAP_RST = 3'h7;
    localparam logic [8:0] SCAN_RST = 9'h001;

    // apb answer sequencer, gray along idle -> fetch -> answer
    typedef enum logic [1:0] {
        RAW_IDLE = 2'b00,
        RAW_FETCH = 2'b01,
        RAW_ANSWER = 2'b11
    } raw_apb_state_t;
endpackage : raw_pkg
`default_nettype wire

/* File: hdl/raw_key_mem.sv */
/*
 * raw_key_mem: small word memory for the cipher key, byte-enable write,
 * two read ports whose data come out of registers one cycle after the index.
 * Assumes one clock with clock enable and an active-low asynchronous reset.
 */
`timescale 1ns/1ns
`default_nettype none
module raw_key_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4,
    parameter int IDX_W = 2
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic [IDX_W-1:0] wr_idx,
    input wire logic [WIDTH/8-1:0] wr_strb,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [IDX_W-1:0] rda_idx,
    output logic [WIDTH-1:0] rda_data_q,
    input wire logic [IDX_W-1:0] rdb_idx,
    output logic [WIDTH-1:0] rdb_data_q
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    for (genvar w = 0; w < DEPTH; w++) begin : g_word
        for (genvar b = 0; b < WIDTH/8; b++) begin : g_byte
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_q[w][b*8 +: 8] <= '0;
                end else if (ce && wr_en && wr_strb[b] && wr_idx == IDX_W'(w)) begin
                    mem_q[w][b*8 +: 8] <= wr_data[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rda_data_q <= '0;
            rdb_data_q <= '0;
        end else if (ce) begin
            rda_data_q <= mem_q[rda_idx];
            rdb_data_q <= mem_q[rdb_idx];
        end
    end
endmodule : raw_key_mem
`default_nettype wire

/* File: hdl/raw_cipher_ctl.sv */
/*
 * raw_cipher_ctl: start bit and mode bit of the cipher engine.
 * Assumes the engine outside gives a one-cycle done pulse per operation.
 */
`timescale 1ns/1ns
`default_nettype none
module raw_cipher_ctl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic ctl_wr,
    input wire logic start_val,
    input wire logic mode_val,
    input wire logic done,
    output logic busy_q,
    output logic mode_q,
    output logic start_pulse_q
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
        end else if (ce) begin
            if (ctl_wr && start_val) begin
                busy_q <= 1'b1;
            end else if (done) begin
                busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_pulse_q <= 1'b0;
        end else if (ce) begin
            start_pulse_q <= ctl_wr && start_val;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= 1'b0;
        end else if (ce && ctl_wr) begin
            mode_q <= mode_val;
        end
    end
endmodule : raw_cipher_ctl
`default_nettype wire

/* File: dv/raw_regs_checker.sv */
/*
 * raw_regs_checker: concurrent checks on the apb handshake and the cipher
 * control ports of raw_regs.
 * Assumes it is bound to raw_regs and that pce is held high.
 */
`timescale 1ns/1ns
`default_nettype none
module raw_regs_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [6:0] round_trip_latency,
    input wire logic cipher_start,
    input wire logic cipher_decipher,
    input wire logic cipher_busy,
    input wire logic cipher_done
);
    logic [31:0] wd_q;
    logic wr_done, wctl, wstart, wpwr;
    assign wr_done = psel && penable && pready && pwrite;
    assign wctl = wr_done && paddr == 32'h4000_00c0 && pstrb[0];
    assign wstart = wctl && pwdata[0];
    assign wpwr = wr_done && paddr == 32'h4000_0080 && pstrb[3];
    // write data of the completing edge, for next-cycle comparisons
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_q <= 32'h0;
        end else begin
            wd_q <= pwdata;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_timing: assert property ($rose(psel) && !penable |-> !pready ##1 !pready ##1 pready)
        else $error("ready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_start_sets_busy: assert property (wstart |=> cipher_start && cipher_busy)
        else $error("start write did not launch");
    a_no_stray_start: assert property (!wstart |=> !cipher_start)
        else $error("start pulse without start write");
    a_mode_follows: assert property (wctl |=> cipher_decipher == wd_q[1])
        else $error("mode bit not stored");
    a_done_clears: assert property (cipher_done && !wstart |=> !cipher_busy)
        else $error("busy not cleared by done");
    a_busy_holds: assert property (cipher_busy && !cipher_done |=> cipher_busy)
        else $error("busy cleared without done");
    a_latency_write: assert property (wpwr |=> round_trip_latency == wd_q[30:24])
        else $error("round trip latency not written");
    c_start: cover property (wstart);
    c_done_busy: cover property (cipher_done && cipher_busy);
    c_error: cover property (pslverr);
endmodule : raw_regs_checker
bind raw_regs raw_regs_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .pslverr, .round_trip_latency, .cipher_start,
    .cipher_decipher, .cipher_busy, .cipher_done);
`default_nettype wire

/* File: dv/tb_top.sv */
/*
 * tb_top: self-checking bench for raw_regs through its apb port.
 * Assumes the raw_regs_checker bind is compiled alongside.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic pclk = 0, presetn = 0, pce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata, radio_ctl_two, radio_ctl_three, key_rd_data;
    logic [3:0] pstrb = 0;
    logic pready, pslverr, cipher_start, cipher_decipher, cipher_busy;
    logic scan_values_load = 0, cipher_done = 0;
    logic [8:0] scan_retreat_value = 0, scan_ceiling_value = 0;
    logic [1:0] key_rd_idx = 0;
    logic [4:0] extended_radio_select;
    logic [6:0] round_trip_latency;
    logic [7:0] receiver_powerup_time, transmitter_powerup_time;
    logic [7:0] private_entry_count, public_entry_count;
    logic [3:0] transmitter_powerdown_ext;
    logic [2:0] beacon_channel_map;
    logic [13:0] beacon_packet_spacing;
    logic [15:0] public_list_start, private_list_start, cipher_block_pointer;
    logic [31:0] ad [14], rv [14], mk [14], pat [2], p, rd;
    logic err;
    int error_cnt = 0, num_checks = 0;

    raw_regs uut (.pclk, .presetn, .pce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .extended_radio_select, .radio_ctl_two, .radio_ctl_three,
        .round_trip_latency, .receiver_powerup_time, .transmitter_powerdown_ext,
        .transmitter_powerup_time, .beacon_channel_map, .beacon_packet_spacing,
        .scan_values_load, .scan_retreat_value, .scan_ceiling_value, .public_list_start,
        .private_list_start, .private_entry_count, .public_entry_count, .cipher_start,
        .cipher_decipher, .cipher_busy, .cipher_done, .cipher_block_pointer, .key_rd_idx,
        .key_rd_data);

    always #5 pclk = ~pclk;

    task summarize;
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer; pready, prdata and pslverr are taken at the completing edge
    task apb(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    task done_pulse;
        @(posedge pclk);
        cipher_done <= 1;
        @(posedge pclk);
        cipher_done <= 0;
    endtask : done_pulse

    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        summarize();
    end

    initial begin
        ad = '{32'h4000_0074, 32'h4000_0078, 32'h4000_007c, 32'h4000_0080, 32'h4000_0090,
            32'h4000_00a0, 32'h4000_00a4, 32'h4000_00b0, 32'h4000_00b4, 32'h4000_00b8,
            32'h4000_00c4, 32'h4000_00c8, 32'h4000_00cc, 32'h4000_00d0};
        rv = '{32'h0, 32'h0, 32'h40, 32'h00d2_03d2, 32'h7, 32'h0, 32'h0001_0001,
            32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
        mk = '{32'h001f_0000, '1, '1, 32'h7fff_0fff, 32'h7, 32'h3fff, 32'h0,
            32'hffff, 32'hffff, 32'hffff, '1, '1, '1, '1};
        pat = '{32'h5a5a_a5a5, 32'ha5a5_5a5a};
        repeat (20) @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 14; i++) begin
            apb(0, ad[i], 32'h0, 4'h0);
            chk(rd, rv[i]);
        end
        apb(0, 32'h4000_00c0, 32'h0, 4'h0);
        chk(rd, 32'h0);
        for (int k = 0; k < 2; k++) begin
            p = pat[k];
            for (int i = 0; i < 14; i++) apb(1, ad[i], p, 4'hf);
            apb(1, 32'h4000_00d4, p, 4'hf);
            for (int i = 0; i < 14; i++) begin
                apb(0, ad[i], 32'h0, 4'h0);
                chk(rd, (p & mk[i]) | (rv[i] & ~mk[i]));
            end
            apb(0, 32'h4000_00d4, 32'h0, 4'h0);
            chk(rd, {16'h0, p[15:0]});
            chk({extended_radio_select, round_trip_latency, receiver_powerup_time,
                transmitter_powerdown_ext, transmitter_powerup_time},
                {p[20:16], p[30:16], p[11:0]});
            chk({15'h0, beacon_channel_map, beacon_packet_spacing},
                {15'h0, p[2:0], p[13:0]});
            chk({public_list_start, private_list_start}, {p[15:0], p[15:0]});
            chk({private_entry_count, public_entry_count, cipher_block_pointer},
                {p[15:0], p[15:0]});
            chk(radio_ctl_two, p);
            chk(radio_ctl_three, p);
        end
        @(posedge pclk);
        key_rd_idx <= 2'h3;
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk(key_rd_data, p);
        apb(1, 32'h4000_00c4, 32'h0, 4'hf);
        apb(1, 32'h4000_00c4, 32'h1122_3344, 4'h4);
        apb(0, 32'h4000_00c4, 32'h0, 4'h0);
        chk(rd, 32'h0022_0000);
        apb(1, 32'h4000_0074, 32'h0002_0000, 4'hf);
        apb(0, 32'h4000_0074, 32'h0, 4'h0);
        chk(rd, 32'h0002_0000);
        apb(0, 32'h4000_0084, 32'h0, 4'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(0, 32'h4000_00c6, 32'h0, 4'h0);
        chk({31'h0, err}, 32'h1);
        @(posedge pclk);
        scan_values_load <= 1;
        scan_retreat_value <= 9'h1ab;
        scan_ceiling_value <= 9'h0cd;
        @(posedge pclk);
        scan_values_load <= 0;
        apb(0, 32'h4000_00a4, 32'h0, 4'h0);
        chk(rd, 32'h01ab_00cd);
        // a load offered while the clock enable is low must be lost
        pce <= 0;
        scan_values_load <= 1;
        scan_retreat_value <= 9'h0aa;
        @(posedge pclk);
        pce <= 1;
        scan_values_load <= 0;
        apb(0, 32'h4000_00a4, 32'h0, 4'h0);
        chk(rd, 32'h01ab_00cd);
        for (int m = 1; m >= 0; m--) begin
            apb(1, 32'h4000_00c0, {30'h0, m[0], 1'b1}, 4'hf);
            @(negedge pclk);
            chk({30'h0, cipher_decipher, cipher_busy}, {30'h0, m[0], 1'b1});
            apb(0, 32'h4000_00c0, 32'h0, 4'h0);
            chk(rd, {30'h0, m[0], 1'b1});
            done_pulse();
            apb(0, 32'h4000_00c0, 32'h0, 4'h0);
            chk(rd, {30'h0, m[0], 1'b0});
        end
        summarize();
    end
endmodule : tb_top
`default_nettype wire
